// ===== src/vdet_cfg.svh
// Purpose: Constants for the voltage detect control block
// Assumes: 16-bit register port, word-indexed offsets
// Notes: Offsets are register indices on the plain port
// Behaviour
// RULE_01: Unit runs only while detect_enable set
// RULE_02: idle_halt suspends unit during Idle mode
// RULE_03: trip_direction picks rising or falling trip
// RULE_04: bandgap_stable_flag shows band gap stable
// RULE_05: No event while reference not stable
// RULE_06: Code 1111 external input, else trip 1-15
// RULE_07: Unimplemented control bits read as zero
// RULE_08: Crossing sets voltage_event_flag, status bit 8
// RULE_09: Sync comparison, one set per crossing, sticky
`ifndef VDET_CFG_SVH
`define VDET_CFG_SVH
`define VDET_ADDR_W 4
`define VDET_OFS_CTRL 4'h0
`define VDET_OFS_STATUS 4'h1
`define VDET_OFS_CLEAR 4'h2
`define VDET_OFS_IRQ_EN 4'h3
`define VDET_BIT_EN 15
`define VDET_BIT_IDLE 13
`define VDET_BIT_DIR 7
`define VDET_BIT_BGST 6
`define VDET_BIT_REFST 5
`define VDET_BIT_EVT 8
`define VDET_CTRL_WMASK 16'hA08F
`define VDET_CTRL_RST 16'h0000
`define VDET_EXT_CODE 4'hF
`endif

// ===== src/vdet_pkg.sv
// Purpose: Types for the voltage detect control block
// Assumes: Constants live in vdet_cfg.svh
// Notes: None
package vdet_pkg;
   typedef logic [15:0] reg16_t;
   typedef enum logic [1:0] {ST_OFF, ST_ARMED, ST_TRIPPED} det_state_t;
endpackage

// ===== src/voltage_detect_control.sv
// Purpose: Control, status and event logic of the voltage detect unit
// Assumes: Analog comparator outside; its result arrives asynchronously
// Notes: Event flag sticky until cleared; set wins over clear
`timescale 1ns/10ps
`include "vdet_cfg.svh"
module voltage_detect_control
   import vdet_pkg::*;
(
   // Clock, reset, enable
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // Register port
   input wire logic [`VDET_ADDR_W-1:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Chip state and analog side
   input wire logic i_idle_mode,
   input wire logic i_bandgap_ok,
   input wire logic i_ref_ok,
   input wire logic i_above_trip,
   output logic o_unit_on,
   output logic o_ext_sense_sel,
   output logic [3:0] o_trip_point,
   // Interrupt
   output logic o_voltage_event_flag,
   output logic o_irq
);
   reg16_t ctrl_q;
   reg16_t ctrl_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic evt_q;
   logic evt_d;
   logic irq_en_q;
   logic [1:0] bg_s_q;
   logic [1:0] ref_s_q;
   logic [1:0] cmp_s_q;
   det_state_t state_q;
   det_state_t state_d;
   wire wr_ctrl = i_wr && (i_addr == `VDET_OFS_CTRL);
   wire wr_clr = i_wr && (i_addr == `VDET_OFS_CLEAR);
   wire wr_en = i_wr && (i_addr == `VDET_OFS_IRQ_EN);
   wire bg_stable = bg_s_q[1];
   wire ref_stable = ref_s_q[1];
   wire cmp_sync = cmp_s_q[1];
   wire dir_up = ctrl_q[`VDET_BIT_DIR];
   wire run = ctrl_q[`VDET_BIT_EN] && !(ctrl_q[`VDET_BIT_IDLE] && i_idle_mode); // RULE_01 RULE_02
   wire tripped = dir_up ? cmp_sync : !cmp_sync; // RULE_03
   wire qualify = run && ref_stable; // RULE_05
   logic set_evt;
   reg16_t status_v;
   reg16_t ctrl_rd;

   assign o_unit_on = run;
   assign o_ext_sense_sel = (ctrl_q[3:0] == `VDET_EXT_CODE); // RULE_06
   assign o_trip_point = 4'hF - ctrl_q[3:0]; // RULE_06
   assign o_voltage_event_flag = evt_q;
   assign o_irq = evt_q && irq_en_q;
   assign o_rdata = rdata_q;

   // Live status flags merged into the control word
   always_comb begin
      ctrl_rd = ctrl_q & `VDET_CTRL_WMASK; // RULE_07
      ctrl_rd[`VDET_BIT_BGST] = bg_stable; // RULE_04
      ctrl_rd[`VDET_BIT_REFST] = ref_stable; // RULE_05
      status_v = 16'h0000;
      status_v[`VDET_BIT_EVT] = evt_q; // RULE_08
   end

   // Read mux
   always_comb begin
      rdata_d = 16'h0000;
      if (i_rd) begin
         case (i_addr)
            `VDET_OFS_CTRL: rdata_d = ctrl_rd;
            `VDET_OFS_STATUS: rdata_d = status_v;
            `VDET_OFS_IRQ_EN: rdata_d = {15'h0000, irq_en_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // Crossing detector: one set per qualifying crossing
   always_comb begin
      state_d = state_q;
      set_evt = 1'b0;
      case (state_q)
         ST_OFF: begin
            if (qualify) begin
               state_d = tripped ? ST_TRIPPED : ST_ARMED;
               set_evt = tripped; // RULE_09
            end
         end
         ST_ARMED: begin
            if (!qualify) begin
               state_d = ST_OFF;
            end else if (tripped) begin
               state_d = ST_TRIPPED;
               set_evt = 1'b1; // RULE_08
            end
         end
         ST_TRIPPED: begin
            if (!qualify) begin
               state_d = ST_OFF;
            end else if (!tripped) begin
               state_d = ST_ARMED;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   always_comb begin
      ctrl_d = wr_ctrl ? (i_wdata & `VDET_CTRL_WMASK) : ctrl_q;
      evt_d = set_evt ? 1'b1 : (wr_clr && i_wdata[`VDET_BIT_EVT]) ? 1'b0 : evt_q; // RULE_09
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         bg_s_q <= 2'h0;
         ref_s_q <= 2'h0;
         cmp_s_q <= 2'h0;
      end else if (i_ce) begin
         bg_s_q <= {bg_s_q[0], i_bandgap_ok};
         ref_s_q <= {ref_s_q[0], i_ref_ok};
         cmp_s_q <= {cmp_s_q[0], i_above_trip}; // RULE_09
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q <= `VDET_CTRL_RST;
         evt_q <= 1'b0;
         irq_en_q <= 1'b0;
         state_q <= ST_OFF;
         rdata_q <= 16'h0000;
      end else if (i_ce) begin
         ctrl_q <= ctrl_d;
         evt_q <= evt_d;
         if (wr_en) begin
            irq_en_q <= i_wdata[`VDET_BIT_EVT];
         end
         state_q <= state_d;
         rdata_q <= rdata_d;
      end
   end
endmodule

// ===== tb/voltage_detect_control_sva.sv
// Purpose: Port assertions for the voltage detect control block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every instance
`timescale 1ns/10ps
module voltage_detect_control_sva (
   // Clock, reset, register port
   input wire logic i_core_clk, i_rstn, i_ce, i_wr, i_rd,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata, o_rdata,
   // Analog side and outputs
   input wire logic i_idle_mode, i_bandgap_ok, i_ref_ok, i_above_trip,
   input wire logic o_unit_on, o_ext_sense_sel, o_voltage_event_flag,
   input wire logic [3:0] o_trip_point
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   wire w0 = i_ce && i_wr && i_addr == 4'h0;
   wire r0 = i_ce && i_rd && i_addr == 4'h0;
   wire clr = i_ce && i_wr && i_addr == 4'h2 && i_wdata[8];
   logic dir_q;
   always_ff @(posedge i_core_clk or negedge i_rstn)
      if (!i_rstn) dir_q <= 1'b0;
      else if (w0) dir_q <= i_wdata[7];
   property p_off; w0 && !i_wdata[15] |=> !o_unit_on; endproperty
   a_off: assert property (p_off) else $error("unit on");
   property p_idle; w0 && i_wdata[15] |=> o_unit_on == !($past(i_wdata[13]) && i_idle_mode); endproperty
   a_idle: assert property (p_idle) else $error("idle halt");
   property p_dir; $rose(o_voltage_event_flag) |-> $past(i_above_trip, 3) == dir_q; endproperty
   a_dir: assert property (p_dir) else $error("direction");
   property p_bg; (i_ce && $stable(i_bandgap_ok))[*4] ##0 r0 |=> o_rdata[6] == $past(i_bandgap_ok); endproperty
   a_bg: assert property (p_bg) else $error("band gap");
   property p_ref; !i_ref_ok [*4] |=> !$rose(o_voltage_event_flag); endproperty
   a_ref: assert property (p_ref) else $error("ref");
   property p_lvl; w0 |=> o_trip_point == 4'hF - $past(i_wdata[3:0]) && o_ext_sense_sel == ($past(i_wdata[3:0]) == 4'hF); endproperty
   a_lvl: assert property (p_lvl) else $error("level");
   property p_zero; r0 |=> (o_rdata & 16'h5F10) == 16'h0000; endproperty
   a_zero: assert property (p_zero) else $error("zero bits");
   property p_hold; o_voltage_event_flag && !clr |=> o_voltage_event_flag; endproperty
   a_hold: assert property (p_hold) else $error("sticky");
   c_wr: cover property (w0);
   c_evt: cover property ($rose(o_voltage_event_flag));
   c_clr: cover property (o_voltage_event_flag ##1 clr);
endmodule
bind voltage_detect_control voltage_detect_control_sva voltage_detect_control_sva_i (.*);

// ===== tb/voltage_detect_control_tb_top.sv
// Purpose: Self-checking bench for the voltage detect control block
// Assumes: Clock enable held high except during one clear write, which is issued with i_ce low
// Notes: Flag follows the comparator after 3 edges
`timescale 1ns/10ps
module voltage_detect_control_tb_top;
   import vdet_pkg::*;
   logic i_core_clk = 0, i_rstn = 0, i_ce = 1, i_wr = 0, i_rd = 0, i_idle_mode = 0, i_bandgap_ok = 0;
   logic i_ref_ok = 0, i_above_trip = 0, o_unit_on, o_ext_sense_sel, o_voltage_event_flag, o_irq;
   logic [3:0] i_addr = 0, o_trip_point;
   reg16_t i_wdata = 0, o_rdata, ctrl;
   int failures = 0, samples_checked = 0;
   always #5 i_core_clk = ~i_core_clk;
   voltage_detect_control voltage_detect_control_i (.*);
   task automatic chk(input reg16_t got, exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [3:0] a, input reg16_t d);
      @(posedge i_core_clk);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 0;
      i_rd <= 0;
      #1 if (!w) chk(o_rdata, d);
   endtask
   task automatic evt(input logic a, input logic e);
      @(posedge i_core_clk);
      i_above_trip <= a;
      repeat (4) @(posedge i_core_clk);
      #1 chk({o_irq, o_voltage_event_flag}, {e, e});
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hCAE9_E01B));
      repeat (12) @(posedge i_core_clk);
      i_rstn <= 1;
      acc(0, 4'h0, 16'h0000);
      i_bandgap_ok <= 1;
      i_ref_ok <= 1;
      for (int i = 0; i < 16; i++) begin
         ctrl = {16'($urandom) & 16'hFFF0} | 16'(i);
         i_idle_mode <= 1'($urandom);
         acc(1, 4'h0, ctrl);
         acc(0, 4'h0, ctrl & 16'hA08F | 16'h0060);
         chk({o_unit_on, o_ext_sense_sel, o_trip_point}, {ctrl[15] && !(ctrl[13] && i_idle_mode), i == 15, 4'(15 - i)});
      end
      $display("register test done");
      i_idle_mode <= 0;
      acc(1, 4'h3, 16'h0100);
      acc(1, 4'h0, 16'h8080);
      acc(1, 4'h2, 16'h0100);
      evt(1, 1);
      acc(1, 4'h1, 16'h0000);
      acc(0, 4'h1, 16'h0100);
      acc(1, 4'h2, 16'h0100);
      evt(1, 0);
      acc(1, 4'h0, 16'h8000);
      evt(0, 1);
      acc(1, 4'h3, 16'h0000);
      chk({o_irq, o_voltage_event_flag}, 16'h0001);
      i_ce <= 0;
      acc(1, 4'h2, 16'h0100);
      chk({o_irq, o_voltage_event_flag}, 16'h0001);
      i_ce <= 1;
      acc(1, 4'h3, 16'h0100);
      acc(1, 4'h0, 16'h8080);
      acc(1, 4'h2, 16'h0100);
      i_ref_ok <= 0;
      evt(1, 0);
      acc(1, 4'h0, 16'h0080);
      i_ref_ok <= 1;
      evt(0, 0);
      evt(1, 0);
      evt(0, 0);
      i_idle_mode <= 1;
      acc(1, 4'h0, 16'hA080);
      evt(1, 0);
      acc(0, 4'h7, 16'h0000);
      $display("event test done");
      end_sim;
   end
endmodule
